// File: cfe_defines.vh
// Constants for the context field encoder: header layout, indicator bits, sizes
`ifndef CFE_DEFINES_VH
`define CFE_DEFINES_VH
`define CFE_PKT_TYPE_CTX   4'h4
`define CFE_HDR_TYPE_MSB   31
`define CFE_HDR_INT_TIME_FMT  2'h1
`define CFE_HDR_FRAC_TIME_FMT 2'h2
`define CFE_IND_CHANGE     31
`define CFE_IND_FREQ       27
`define CFE_IND_GAIN       23
`define CFE_FREQ_FRAC_BITS 20
`define CFE_GAIN_FRAC_BITS 7
`define CFE_HDR_WORDS      16'h0006
`define CFE_FIFO_DEPTH     8
`define CFE_FIFO_AW        3
`define CFE_RX_STREAM_ID   32'h9000_0001
`define CFE_DG_STREAM_ID   32'h9000_0002
`endif

// File: cfe_encoder.v
// Context packet encoder: change tracking, field words and header sequence
`timescale 1ns/1ps
`default_nettype none
`include "cfe_defines.vh"

module cfe_encoder (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Context values, frequency Hz 44.20, gains dB 9.7
  input  wire [63:0] freq_hz,
  input  wire [15:0] gain_rf,
  input  wire [15:0] gain_if,
  // Timestamp inputs
  input  wire [31:0] ts_seconds,
  input  wire [63:0] ts_picosec,
  // Packet request, pulse; selects receiver or digitizer packet
  input  wire        send_req,
  input  wire        send_digitizer,
  input  wire        force_all,
  // Status
  output reg         busy,
  output reg  [3:0]  pkt_count,
  output reg  [31:0] indicator_word,
  // Word stream, word_last marks last word
  output reg  [31:0] word_data,
  output reg         word_last,
  output reg         word_valid,
  input  wire        word_ready
);
  localparam ST_IDLE = 2'd0;
  localparam ST_EMIT = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [1:0]  state_q;
  reg [3:0]  idx_q;
  reg [3:0]  nwords_q;
  reg        dig_q;
  reg        frq_ch_q;
  reg        gn_ch_q;
  reg [63:0] last_freq_q;
  reg [31:0] last_gain_q;
  reg        seen_q;
  reg [3:0]  count_q;
  reg [63:0] snap_freq_q;
  reg [31:0] snap_gain_q;
  reg [31:0] snap_sec_q;
  reg [63:0] snap_ps_q;
  reg [31:0] cur_word;
  reg        push_d;
  wire       fifo_ready;
  wire [32:0] fifo_out;
  wire       fifo_valid;
  wire       fifo_pop;
  wire [31:0] gain_word;
  wire       frq_diff;
  wire       gn_diff;
  wire [31:0] ind_word;
  wire [31:0] hdr_word;

  // Gain halves: IF above, RF below; inputs already scaled by 128
  assign gain_word = {gain_if, gain_rf};

  // Compare against the last values actually reported
  assign frq_diff = !seen_q | force_all | (freq_hz != last_freq_q);
  assign gn_diff  = !seen_q | force_all | (gain_word != last_gain_q);

  // Indicator word; digitizer fields are outside this block, so only the
  // change bit can be set there and it is left clear
  assign ind_word = dig_q ? 32'h0000_0000 :
                    {(frq_ch_q | gn_ch_q), 3'b000, frq_ch_q, 3'b000, gn_ch_q,
                     23'h00_0000};

  // Header word: type, no class id, reserved, precise time, time formats,
  // count, size
  assign hdr_word = {`CFE_PKT_TYPE_CTX, 1'b0, 2'b00, 1'b0, `CFE_HDR_INT_TIME_FMT,
                     `CFE_HDR_FRAC_TIME_FMT, count_q, 12'h000, nwords_q};

  // Number of words for a packet with the chosen fields
  function [3:0] cfe_words;
    input f;
    input g;
    begin
      cfe_words = 4'd6 + {2'b00, f, 1'b0} + {3'b000, g};
    end
  endfunction

  // Word selection by index; fields in indicator bit order
  always @* begin
    cur_word = 32'h0000_0000;
    case (idx_q)
      4'd0: cur_word = hdr_word;
      4'd1: cur_word = dig_q ? `CFE_DG_STREAM_ID : `CFE_RX_STREAM_ID;
      4'd2: cur_word = snap_sec_q;
      4'd3: cur_word = snap_ps_q[63:32];
      4'd4: cur_word = snap_ps_q[31:0];
      4'd5: cur_word = ind_word;
      4'd6: cur_word = frq_ch_q ? snap_freq_q[63:32] : snap_gain_q;
      4'd7: cur_word = snap_freq_q[31:0];
      4'd8: cur_word = snap_gain_q;
      default: cur_word = 32'h0000_0000;
    endcase
  end

  // Sequencer; stalls on a full FIFO so back-pressure reaches the source
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      idx_q       <= 4'd0;
      nwords_q    <= 4'd0;
      dig_q       <= 1'b0;
      frq_ch_q    <= 1'b0;
      gn_ch_q     <= 1'b0;
      last_freq_q <= 64'h0000_0000_0000_0000;
      last_gain_q <= 32'h0000_0000;
      seen_q      <= 1'b0;
      count_q     <= 4'h0;
      snap_freq_q <= 64'h0000_0000_0000_0000;
      snap_gain_q <= 32'h0000_0000;
      snap_sec_q  <= 32'h0000_0000;
      snap_ps_q   <= 64'h0000_0000_0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= 4'd0;
          if (send_req) begin
            dig_q       <= send_digitizer;
            frq_ch_q    <= !send_digitizer & frq_diff;
            gn_ch_q     <= !send_digitizer & gn_diff;
            nwords_q    <= send_digitizer ? 4'd6 :
                           cfe_words(frq_diff, gn_diff);
            snap_freq_q <= freq_hz;
            snap_gain_q <= gain_word;
            snap_sec_q  <= ts_seconds;
            snap_ps_q   <= ts_picosec;
            if (!send_digitizer) begin
              last_freq_q <= freq_hz;
              last_gain_q <= gain_word;
              seen_q      <= 1'b1;
            end
            state_q <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (fifo_ready) begin
            if (idx_q == nwords_q - 4'd1) begin
              state_q <= ST_DONE;
            end else if (idx_q == 4'd6 && !frq_ch_q) begin
              idx_q <= 4'd8;
            end else begin
              idx_q <= idx_q + 4'd1;
            end
          end
        end
        ST_DONE: begin
          count_q <= count_q + 4'd1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    push_d = (state_q == ST_EMIT);
  end

  cfe_fifo #(
    .WIDTH (33),
    .DEPTH (`CFE_FIFO_DEPTH),
    .AW    (`CFE_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_data   ({(idx_q == nwords_q - 4'd1), cur_word}),
    .in_valid  (push_d),
    .in_ready  (fifo_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Output register stage; pops when empty or being taken
  assign fifo_pop = fifo_valid & (!word_valid | word_ready);

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      word_valid     <= 1'b0;
      word_data      <= 32'h0000_0000;
      word_last      <= 1'b0;
      busy           <= 1'b0;
      pkt_count      <= 4'h0;
      indicator_word <= 32'h0000_0000;
    end else begin
      if (fifo_pop) begin
        word_data  <= fifo_out[31:0];
        word_last  <= fifo_out[32];
        word_valid <= 1'b1;
      end else if (word_ready) begin
        word_valid <= 1'b0;
      end
      busy           <= (state_q != ST_IDLE) | send_req;
      pkt_count      <= count_q;
      indicator_word <= ind_word;
    end
  end
endmodule // cfe_encoder
`default_nettype wire

// File: cfe_encoder_test.sv
// Self-checking bench for the context field encoder
`timescale 1ns/1ps
`default_nettype none
module cfe_encoder_test;
  logic clk_sys = 1'b0, rst_n = 1'b0, send_req = 1'b0, send_digitizer = 1'b0, hold = 1'b0;
  logic force_all = 1'b0;
  logic [63:0] freq_hz = {12'h000, 32'h8F0D_1800, 20'h8_0000}; // 2.4 GHz plus half a Hz
  logic [15:0] gain_rf = 16'hFE40; // -3.5 dB times 128
  logic [15:0] gain_if = 16'h0A20; // 20.25 dB times 128
  logic [31:0] ts_seconds = 32'h5CF4_E2A0;
  logic [63:0] ts_picosec = 64'h0000_0000_1234_5678;
  wire logic busy, word_last, word_valid, word_ready;
  wire logic [3:0] pkt_count;
  wire logic [31:0] indicator_word, word_data;
  int bad_count = 0, cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  cfe_encoder u_dut (.clk_sys, .rst_n, .freq_hz, .gain_rf, .gain_if, .ts_seconds, .ts_picosec,
    .send_req, .send_digitizer, .force_all, .busy, .pkt_count, .indicator_word,
    .word_data, .word_last, .word_valid, .word_ready);
  cfe_host u_host (.clk_sys, .hold, .word_data, .word_last, .word_valid, .word_ready);
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
    end
  endtask
  // One packet: expected words built from the field layout, then compared
  task automatic run(input logic dig, input logic [31:0] ind, input logic [3:0] cnt, input int st);
    logic [32:0] e[$];
    int n;
    n = 6 + (ind[27] ? 2 : 0) + (ind[23] ? 1 : 0);
    e.push_back({1'b0, 12'h406, cnt, n[15:0]});
    e.push_back({1'b0, 28'h900_0000, 2'b00, dig, !dig});
    e.push_back({1'b0, ts_seconds});
    e.push_back({1'b0, ts_picosec[63:32]});
    e.push_back({1'b0, ts_picosec[31:0]});
    e.push_back({1'b0, ind});
    if (ind[27]) e.push_back({1'b0, freq_hz[63:32]});
    if (ind[27]) e.push_back({1'b0, freq_hz[31:0]});
    if (ind[23]) e.push_back({1'b0, gain_if, gain_rf});
    e[n-1] = e[n-1] | 33'h1_0000_0000;
    hold = (st > 0);
    send_req = 1'b1;
    @(negedge clk_sys) send_req = 1'b0;
    chk({32'h0, busy}, 33'h1);
    repeat (st) @(negedge clk_sys);
    // A stalled header must stand on the stream output
    if (st > 0) chk({word_valid, word_data}, {1'b1, 12'h406, cnt, n[15:0]});
    hold = 1'b0;
    for (int i = 0; i < 200 && u_host.got.size() < n; i++) @(negedge clk_sys);
    if (u_host.got.size() != n) begin
      bad_count++;
      $display("CHECK FAILED %0t word count %0d", $time, u_host.got.size());
      tally_and_finish;
    end
    foreach (e[i]) chk(u_host.got[i], e[i]);
    u_host.got.delete();
    repeat (4) @(negedge clk_sys);
    chk({29'h0, pkt_count}, {29'h0, cnt + 4'h1});
    chk({1'b0, indicator_word}, {1'b0, ind});
  endtask
  // All fields after reset, FIFO filled by a long stall
  task t_first; run(1'b0, 32'h8880_0000, 4'h0, 12); $display("first done"); endtask
  task t_same; run(1'b0, 32'h0000_0000, 4'h1, 0); $display("same done"); endtask
  task t_gain; gain_rf = 16'h0080; run(1'b0, 32'h8080_0000, 4'h2, 0); $display("gain done"); endtask
  task t_freq; freq_hz[20] = 1'b1; run(1'b0, 32'h8800_0000, 4'h3, 0); $display("freq done"); endtask
  task t_digi;
    send_digitizer = 1'b1;
    run(1'b1, 32'h0, 4'h4, 0);
    send_digitizer = 1'b0;
    $display("digi done");
  endtask
  // Unchanged values reported in full when forced
  task t_force;
    force_all = 1'b1;
    run(1'b0, 32'h8880_0000, 4'h5, 0);
    force_all = 1'b0;
    $display("force done");
  endtask
  // Count runs through 15 and wraps to zero
  task t_wrap;
    for (int k = 6; k <= 16; k++) run(1'b0, 32'h0, k[3:0], 0);
    $display("wrap done");
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    t_first();
    t_same();
    t_gain();
    t_freq();
    t_digi();
    t_force();
    t_wrap();
    tally_and_finish;
  end
endmodule // cfe_encoder_test
bind cfe_encoder cfe_chk u_chk (.clk_sys, .rst_n, .busy, .pkt_count, .indicator_word,
  .word_data, .word_last, .word_valid, .word_ready);
`default_nettype wire

// File: cfe_fifo.v
// Word FIFO between the packet sequencer and the stream consumer
`timescale 1ns/1ps
`default_nettype none
module cfe_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // Fill side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Drain side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage has no reset; only pointers and the fill count need a defined value
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // cfe_fifo
`default_nettype wire

// File: cfe_host.sv
// Stream consumer model with periodic and commanded stalls
`timescale 1ns/1ps
`default_nettype none
module cfe_host (
  // Clock and stream
  input  wire logic        clk_sys,
  input  wire logic        hold,
  input  wire logic [31:0] word_data,
  input  wire logic        word_last,
  input  wire logic        word_valid,
  output var  logic        word_ready
);
  logic [32:0] got[$];
  logic [1:0]  ph_q = 2'h0;
  initial word_ready = 1'b0;
  // Records every accepted word with its last flag; a stall one cycle in three backs up the FIFO
  always @(posedge clk_sys) begin
    if (word_valid && word_ready) got.push_back({word_last, word_data});
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    word_ready <= !hold && (ph_q != 2'h2);
  end
endmodule // cfe_host
`default_nettype wire

// File: cfe_sva.sv
// Assertions on the context encoder's status outputs and output stream
`timescale 1ns/1ps
`default_nettype none
module cfe_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Observed ports
  input wire logic        busy,
  input wire logic [3:0]  pkt_count,
  input wire logic [31:0] indicator_word,
  input wire logic [31:0] word_data,
  input wire logic        word_last,
  input wire logic        word_valid,
  input wire logic        word_ready
);
  logic        mid_q;
  logic [15:0] cnt_q;
  logic [15:0] size_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Packet position; the word after a last word is a header
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      mid_q  <= 1'b0;
      cnt_q  <= 16'h0000;
      size_q <= 16'h0000;
    end else if (word_valid && word_ready) begin
      mid_q <= !word_last;
      cnt_q <= word_last ? 16'h0000 : cnt_q + 16'h0001;
      size_q <= mid_q ? size_q : word_data[15:0];
    end
  end
  AST_CHG_NAMES: assert property (indicator_word[31] |-> indicator_word[27] || indicator_word[23])
    else $error("change bit with no field bit");
  AST_CHG_SET: assert property (indicator_word[27] || indicator_word[23] |-> indicator_word[31])
    else $error("field bit with no change bit");
  AST_IND_RSVD: assert property ((indicator_word & 32'h777F_FFFF) == 32'h0000_0000)
    else $error("undefined indicator bit set");
  AST_HOLD: assert property (word_valid && !word_ready |=> word_valid && $stable(word_data))
    else $error("stalled word changed");
  AST_COUNT: assert property (pkt_count != $past(pkt_count) |-> pkt_count == $past(pkt_count) + 4'h1)
    else $error("packet count skipped");
  AST_HDR_TYPE: assert property (word_valid && !mid_q |-> word_data[31:20] == 12'h406)
    else $error("bad header type bits");
  AST_SIZE: assert property (word_valid && word_ready && word_last |-> cnt_q + 16'h0001 == size_q)
    else $error("word count differs from header size");
  AST_ANSWER: assert property ($rose(busy) |-> ##[0:3] word_valid)
    else $error("no word after start");
endmodule // cfe_chk
`default_nettype wire
